// File: hw/ptl_crossing.v
// One position trigger's wrap-aware threshold crossing detector.
// Assumes prevPos and curPos are two consecutive valid samples.
`timescale 1ns/1ns
module ptl_crossing (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  // Sample control
  input  wire        sample,
  input  wire        pairValid,
  input  wire        rearmAll,
  // Positions
  input  wire [15:0] prevPos,
  input  wire [15:0] curPos,
  input  wire [15:0] threshold,
  input  wire [14:0] hyst,
  // Results
  output wire        crossUp,
  output wire        crossDown
);

  reg         armUp;
  reg         armDown;
  wire [15:0] dPrev   = prevPos - threshold;
  wire [15:0] dCur    = curPos - threshold;
  wire [15:0] delta   = curPos - prevPos;
  wire [16:0] sumPath = {dPrev[15], dPrev} + {delta[15], delta};
  wire [16:0] hyst17  = {2'b00, hyst};
  wire [16:0] belowLo = {dCur[15], dCur} + hyst17;
  wire [16:0] aboveHi = {dCur[15], dCur} - hyst17;

  // Shortest path around the wrapped range decides direction
  wire rawUp   = !delta[15] && (delta != 16'h0000) && dPrev[15] && !sumPath[16];
  wire rawDown = delta[15] && !dPrev[15] && sumPath[16];

  assign crossUp   = pairValid && rawUp && armUp;
  assign crossDown = pairValid && rawDown && armDown;

  // ----------------------------------------------------------------
  // Hysteresis arming
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      armUp   <= 1'b1;
      armDown <= 1'b1;
    end else if (ce) begin
      if (rearmAll) begin
        armUp   <= 1'b1;
        armDown <= 1'b1;
      end else if (sample) begin
        // Refire only after moving back past the hysteresis band
        if (crossUp)
          armUp <= 1'b0;
        else if (belowLo[16])
          armUp <= 1'b1;
        if (crossDown)
          armDown <= 1'b0;
        else if (!aboveHi[16] && (aboveHi != 17'h00000))
          armDown <= 1'b1;
      end
    end
  end

endmodule // ptl_crossing

// File: hw/ptl_trigger_io.v
// Per-sensor user IO logic: position triggers, status LED, mismatch
// diagnostic, key-protected save or factory restore of defaults and a keyless factory restore on firmware update.
// Assumes the measurement engine pulses measDone once per result and
// that configuration ports are held by a register file elsewhere.
`timescale 1ns/1ns
`include "ptl_defs.vh"

module ptl_trigger_io #(
  parameter NTRIG          = 8,
  parameter NIO            = 4,
  parameter BLINK_HALF_CYC = (`PTL_BLINK_HALF_MS * 1000000) / `PTL_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire                 clk,
  input  wire                 srst,
  input  wire                 ce,
  // Measurement results
  input  wire                 measDone,
  input  wire                 measValid,
  input  wire [11:0]          measAmplitude,
  input  wire [2:0]           sensorType,
  input  wire [7:0]           sensorSubtype,
  input  wire [15:0]          reportedPosition16,
  input  wire [31:0]          reportedPosition32,
  input  wire [15:0]          coarsePosition,
  input  wire [15:0]          finePosition,
  // Sensor control word
  input  wire                 continuousRun,
  input  wire                 startBit,
  input  wire                 triggerRunEnable,
  input  wire                 incrementalEnable,
  output wire                 measureRequest,
  // LED control word
  input  wire [3:0]           ledIoSelect,
  input  wire [11:0]          ledAmplitudeThreshold,
  // IO polarity config
  input  wire [NIO-1:0]       ioActiveHigh,
  // Trigger configuration
  input  wire [NTRIG-1:0]     triggerEnable,
  input  wire [NTRIG*4-1:0]   triggerIoSelect,
  input  wire [NTRIG*16-1:0]  triggerPosition,
  input  wire [NTRIG*2-1:0]   triggerDirection,
  input  wire [NTRIG*2-1:0]   triggerAction,
  input  wire                 triggerAutoClear,
  input  wire [14:0]          triggerHysteresisSetting,
  input  wire [NTRIG-1:0]     triggerFlagClear,
  output reg  [NTRIG-1:0]     triggerFlag,
  // Diagnostics and pins
  output reg  [15:0]          positionMismatch,
  output reg  [NIO-1:0]       ioOut,
  // Defaults storage control
  input  wire                 keyWrite,
  input  wire [15:0]          keyData,
  input  wire                 saveBit,
  input  wire                 factoryBit,
  input  wire                 firmwareUpdated,
  input  wire                 nvmWriteDone,
  output reg                  nvmWriteStrobe,
  output reg                  nvmRestoreFactory,
  output reg                  deviceResetRequest
);

  localparam PULSE_CYC = (`PTL_PULSE_NS + `PTL_CLK_PERIOD_NS - 1) / `PTL_CLK_PERIOD_NS;
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WRITE = 2'h1;
  localparam [1:0] ST_RESET = 2'h2;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [15:0] scalePos;
    input [2:0]  stype;
    input [7:0]  sub;
    input [15:0] p16;
    input [31:0] p32;
    reg   [31:0] q;
    begin
      q = 32'h00000000;
      case (stype)
        `PTL_TYPE_2: q = $signed(p32) / `PTL_DIV_TYPE_2;
        `PTL_TYPE_3: q = $signed(p32) / `PTL_DIV_TYPE_3;
        `PTL_TYPE_6: q = (sub == 8'h00) ? $signed(p32) : $signed(p32) / $signed({24'h000000, sub});
        default:     q = {16'h0000, p16};
      endcase
      scalePos = q[15:0];
    end
  endfunction

  function ioMapped;
    input [3:0] sel;
    input integer io;
    begin
      ioMapped = (sel != 4'h0) && ({28'h0000000, sel} == io + 1);
    end
  endfunction

  // ----------------------------------------------------------------
  // Sample tracking
  // ----------------------------------------------------------------
  reg  [15:0] prevPos;
  reg  [15:0] lastPos;
  reg         prevValid;
  reg         haveLast;
  wire [15:0] curPos     = scalePos(sensorType, sensorSubtype, reportedPosition16,
                                    reportedPosition32);
  wire        validTick  = ce && measDone && measValid;
  wire        pairValid  = prevValid;
  wire        trigSample = validTick && triggerRunEnable;

  assign measureRequest = continuousRun && startBit;

  always @(posedge clk) begin
    if (srst) begin
      prevPos          <= 16'h0000;
      lastPos          <= 16'h0000;
      prevValid        <= 1'b0;
      haveLast         <= 1'b0;
      positionMismatch <= 16'h0000;
    end else if (ce && measDone) begin
      prevValid <= measValid;
      if (measValid) begin
        prevPos  <= curPos;
        lastPos  <= reportedPosition16;
        haveLast <= 1'b1;
        if (incrementalEnable)
          positionMismatch <= haveLast ? reportedPosition16 - lastPos : 16'h0000;
        else
          positionMismatch <= coarsePosition - finePosition;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger crossing detectors
  // ----------------------------------------------------------------
  wire [NTRIG-1:0] crossUp;
  wire [NTRIG-1:0] crossDown;
  wire [NTRIG-1:0] fireUp;
  wire [NTRIG-1:0] fireDown;
  wire [NTRIG-1:0] fired;

  genvar g;
  generate
    for (g = 0; g < NTRIG; g = g + 1) begin : gTrig
      ptl_crossing uCross (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .sample    (trigSample),
        .pairValid (pairValid),
        .rearmAll  (ce && measDone && !measValid),
        .prevPos   (prevPos),
        .curPos    (curPos),
        .threshold (triggerPosition[g*16 +: 16]),
        .hyst      (triggerHysteresisSetting),
        .crossUp   (crossUp[g]),
        .crossDown (crossDown[g])
      );
      assign fireUp[g]   = trigSample && triggerEnable[g] && crossUp[g] &&
                           triggerDirection[g*2 + `PTL_DIR_POS_BIT];
      assign fireDown[g] = trigSample && triggerEnable[g] && crossDown[g] &&
                           triggerDirection[g*2 + `PTL_DIR_NEG_BIT];
      assign fired[g]    = fireUp[g] || fireDown[g];
    end
  endgenerate

  // Hardware set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (srst)
      triggerFlag <= {NTRIG{1'b0}};
    else if (ce)
      triggerFlag <= (triggerFlag & ~triggerFlagClear) | fired;
  end

  // ----------------------------------------------------------------
  // LED status
  // ----------------------------------------------------------------
  reg        ledValid;
  reg        ledStrong;
  reg        blinkPhase;
  reg [31:0] blinkCount;
  reg [NIO-1:0] ledPolarity;

  always @(posedge clk) begin
    if (srst) begin
      ledValid   <= 1'b0;
      ledStrong  <= 1'b0;
      blinkPhase <= 1'b0;
      blinkCount <= 32'h00000000;
      ledPolarity <= {NIO{1'b1}};
    end else if (ce) begin
      if (measDone) begin
        ledValid  <= measValid;
        ledStrong <= (measAmplitude >= ledAmplitudeThreshold);
      end
      if (blinkCount >= BLINK_HALF_CYC - 1) begin
        blinkCount <= 32'h00000000;
        blinkPhase <= !blinkPhase;
      end else begin
        blinkCount <= blinkCount + 32'h00000001;
      end
      if (ledIoSelect == 4'h0)
        ledPolarity <= ioActiveHigh;
    end
  end

  wire ledActive = ledStrong || (ledValid && blinkPhase);

  // ----------------------------------------------------------------
  // IO drive
  // ----------------------------------------------------------------
  reg [NIO-1:0] ioState;
  reg [NIO-1:0] next_ioState;
  reg [NIO-1:0] pulseStart;
  reg [NIO-1:0] holdActive;
  reg [NIO-1:0] pulseOn;
  reg [15:0]    pulseCount [0:NIO-1];
  reg [NIO-1:0] next_ioOut;
  reg           active;
  reg           pol;
  reg [1:0]     act;
  integer       i;
  integer       t;
  integer       k;

  always @* begin
    next_ioState = ioState;
    pulseStart   = {NIO{1'b0}};
    holdActive   = {NIO{1'b0}};
    next_ioOut   = {NIO{1'b0}};
    active       = 1'b0;
    pol          = 1'b0;
    act          = 2'h0;
    for (i = 0; i < NIO; i = i + 1) begin
      for (t = 0; t < NTRIG; t = t + 1) begin
        act = triggerAction[t*2 +: 2];
        if (ioMapped(triggerIoSelect[t*4 +: 4], i)) begin
          case (act)
            `PTL_ACT_ACTIVATE: begin
              if (fired[t] && triggerAutoClear)
                pulseStart[i] = 1'b1;
              if (triggerFlag[t] && !triggerAutoClear)
                holdActive[i] = 1'b1;
            end
            `PTL_ACT_TOGGLE: begin
              if (fired[t])
                next_ioState[i] = !next_ioState[i];
            end
            `PTL_ACT_LOW_UP: begin
              if (fireUp[t])
                next_ioState[i] = !ioActiveHigh[i];
              else if (fireDown[t])
                next_ioState[i] = ioActiveHigh[i];
            end
            `PTL_ACT_HIGH_UP: begin
              if (fireUp[t])
                next_ioState[i] = ioActiveHigh[i];
              else if (fireDown[t])
                next_ioState[i] = !ioActiveHigh[i];
            end
            default: begin
              next_ioState[i] = next_ioState[i];
            end
          endcase
        end
      end
      // Logical active is mapped to the pin through its polarity
      active = ioState[i] || holdActive[i] || pulseOn[i] ||
               (ioMapped(ledIoSelect, i) && ledActive);
      pol    = ioMapped(ledIoSelect, i) ? ledPolarity[i] : ioActiveHigh[i];
      next_ioOut[i] = pol ? active : !active;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      ioState <= {NIO{1'b0}};
      pulseOn <= {NIO{1'b0}};
      ioOut   <= {NIO{1'b0}};
      for (k = 0; k < NIO; k = k + 1)
        pulseCount[k] <= 16'h0000;
    end else if (ce) begin
      ioState <= next_ioState;
      ioOut   <= next_ioOut;
      for (k = 0; k < NIO; k = k + 1) begin
        if (pulseStart[k]) begin
          pulseOn[k]    <= 1'b1;
          pulseCount[k] <= PULSE_CYC[15:0];
        end else if (pulseCount[k] > 16'h0001) begin
          pulseCount[k] <= pulseCount[k] - 16'h0001;
        end else begin
          pulseCount[k] <= 16'h0000;
          pulseOn[k]    <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Defaults save and factory restore
  // ----------------------------------------------------------------
  reg [1:0] nvmState;
  reg       unlocked;

  always @(posedge clk) begin
    if (srst) begin
      nvmState           <= ST_IDLE;
      unlocked           <= 1'b0;
      nvmWriteStrobe     <= 1'b0;
      nvmRestoreFactory  <= 1'b0;
      deviceResetRequest <= 1'b0;
    end else if (ce) begin
      nvmWriteStrobe     <= 1'b0;
      deviceResetRequest <= 1'b0;
      if (keyWrite)
        unlocked <= (keyData == `PTL_UNLOCK_KEY);
      case (nvmState)
        ST_IDLE: begin
          if (firmwareUpdated) begin
            nvmRestoreFactory <= 1'b1;
            nvmWriteStrobe    <= 1'b1;
            nvmState          <= ST_WRITE;
          end else if (unlocked && (saveBit || factoryBit)) begin
            unlocked          <= 1'b0;
            nvmRestoreFactory <= factoryBit;
            nvmWriteStrobe    <= 1'b1;
            nvmState          <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (nvmWriteDone)
            nvmState <= ST_RESET;
        end
        ST_RESET: begin
          deviceResetRequest <= 1'b1;
          nvmState           <= ST_IDLE;
        end
        default: begin
          nvmState <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ptl_trigger_io

// File: pkg/ptl_defs.vh
// Constants shared by the position trigger and LED IO logic.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef PTL_DEFS_VH
`define PTL_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTL_CLK_PERIOD_NS   10
`define PTL_BLINK_HALF_MS   250
`define PTL_PULSE_NS        1000

// ----------------------------------------------------------------
// Key and field encodings
// ----------------------------------------------------------------
`define PTL_UNLOCK_KEY      16'h0C1C
`define PTL_DIR_POS_BIT     0
`define PTL_DIR_NEG_BIT     1
`define PTL_ACT_ACTIVATE    2'h0
`define PTL_ACT_TOGGLE      2'h1
`define PTL_ACT_LOW_UP      2'h2
`define PTL_ACT_HIGH_UP     2'h3
`define PTL_TYPE_1          3'h1
`define PTL_TYPE_2          3'h2
`define PTL_TYPE_3          3'h3
`define PTL_TYPE_4          3'h4
`define PTL_TYPE_6          3'h6
`define PTL_DIV_TYPE_2      12
`define PTL_DIV_TYPE_3      3
`define PTL_HYST_RESET      15'h0000

`endif

// File: tb/ptl_nvm_model.sv
// Storage partner: answers each write strobe with one done pulse.
// Assumes the bench sets the answer latency, one or more cycles.
`timescale 1ns/1ns
module ptl_nvm_model (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Write handshake
  input  wire [7:0] latency,
  input  wire       nvmWriteStrobe,
  output reg        nvmWriteDone = 1'b0
);
  integer left = 0;

  always @(posedge clk) begin
    nvmWriteDone <= 1'b0;
    if (srst) begin
      left <= 0;
    end else if (nvmWriteStrobe) begin
      left <= latency;
    end else if (left == 1) begin
      nvmWriteDone <= 1'b1;
      left         <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule // ptl_nvm_model

// File: tb/ptl_trigger_io_assertions.sv
// Concurrent checks on the ports of the trigger and LED IO block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module ptl_trigger_io_assertions #(
  parameter NTRIG = 8
) (
  // Clock and reset
  input logic             clk,
  input logic             srst,
  // Measurement and run control
  input logic             measDone,
  input logic             measValid,
  input logic             triggerRunEnable,
  input logic             continuousRun,
  input logic             startBit,
  input logic             measureRequest,
  // Triggers and diagnostics
  input logic [NTRIG-1:0] triggerEnable,
  input logic [NTRIG-1:0] triggerFlagClear,
  input logic [NTRIG-1:0] triggerFlag,
  input logic [15:0]      positionMismatch,
  // Defaults storage
  input logic             keyWrite,
  input logic [15:0]      keyData,
  input logic             saveBit,
  input logic             factoryBit,
  input logic             firmwareUpdated,
  input logic             nvmWriteDone,
  input logic             nvmWriteStrobe,
  input logic             nvmRestoreFactory,
  input logic             deviceResetRequest
);
  // ----------------------------------------------------------------
  // Key tracking and properties
  // ----------------------------------------------------------------
  logic unlocked;
  logic fwLast;

  // A firmware-driven write leaves the unlock untouched
  always @(posedge clk) begin
    fwLast <= firmwareUpdated;
    if (srst)
      unlocked <= 1'b0;
    else if (keyWrite)
      unlocked <= (keyData == 16'h0C1C);
    else if (nvmWriteStrobe && !fwLast)
      unlocked <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_request_level: assert property (measureRequest == (continuousRun && startBit))
    else $error("measure request does not follow run and start");
  a_strobe_alone: assert property (nvmWriteStrobe |=> !nvmWriteStrobe [*2])
    else $error("second storage write too soon");
  a_key_needed: assert property (nvmWriteStrobe |->
    $past(firmwareUpdated || (unlocked && (saveBit || factoryBit))))
    else $error("storage write without unlock");
  a_write_kind: assert property (nvmWriteStrobe |->
    nvmRestoreFactory == $past(factoryBit || firmwareUpdated))
    else $error("storage write kind wrong");
  a_reset_after: assert property ($rose(deviceResetRequest) |-> $past(nvmWriteDone, 2))
    else $error("device reset not two cycles after done");
  a_reset_pulse: assert property (deviceResetRequest |=> !deviceResetRequest)
    else $error("device reset longer than one cycle");
  a_flag_sticky: assert property (!$past(srst) |->
    ($past(triggerFlag) & ~triggerFlag & ~$past(triggerFlagClear)) == '0)
    else $error("flag dropped without clear");
  a_flag_cause: assert property (!$past(srst) && (triggerFlag & ~$past(triggerFlag)) != '0
    |-> $past(measDone && measValid && triggerRunEnable))
    else $error("flag set without valid running sample");
  a_flag_enable: assert property (!$past(srst) |->
    (triggerFlag & ~$past(triggerFlag) & ~$past(triggerEnable)) == '0)
    else $error("disabled trigger set its flag");
  a_mismatch_hold: assert property ($changed(positionMismatch) |->
    $past(measDone) || $past(srst))
    else $error("mismatch changed without a measurement");

  c_save: cover property (nvmWriteStrobe && !nvmRestoreFactory);
  c_factory: cover property (nvmWriteStrobe && nvmRestoreFactory);
  c_reset: cover property (deviceResetRequest);
  c_flag: cover property (|triggerFlag);
endmodule // ptl_trigger_io_assertions

bind ptl_trigger_io ptl_trigger_io_assertions #(.NTRIG(NTRIG)) u_ptl_trigger_io_assertions (
  .clk(clk), .srst(srst), .measDone(measDone), .measValid(measValid),
  .triggerRunEnable(triggerRunEnable), .continuousRun(continuousRun), .startBit(startBit),
  .measureRequest(measureRequest), .triggerEnable(triggerEnable),
  .triggerFlagClear(triggerFlagClear), .triggerFlag(triggerFlag),
  .positionMismatch(positionMismatch), .keyWrite(keyWrite), .keyData(keyData),
  .saveBit(saveBit), .factoryBit(factoryBit), .firmwareUpdated(firmwareUpdated),
  .nvmWriteDone(nvmWriteDone), .nvmWriteStrobe(nvmWriteStrobe),
  .nvmRestoreFactory(nvmRestoreFactory), .deviceResetRequest(deviceResetRequest)
);

// File: tb/tb.sv
// Self-checking bench for the trigger and LED IO block.
// Assumes the storage model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  reg          clk = 1'b0;
  reg          srst = 1'b1;
  reg          ce = 1'b1;
  reg          measDone = 1'b0;
  reg          measValid = 1'b0;
  reg  [11:0]  measAmp = 12'h000;
  reg  [15:0]  pos16 = 16'h0000;
  reg  [15:0]  fine = 16'h0000;
  reg  [15:0]  coarse = 16'h0000;
  reg  [14:0]  hyst = 15'h0000;
  reg          startBit = 1'b1;
  reg          runEnable = 1'b1;
  reg          incEnable = 1'b0;
  reg  [3:0]   ledSel = 4'h0;
  reg  [3:0]   ioHigh = 4'hF;
  reg  [7:0]   trigEn = 8'h03;
  reg  [31:0]  trigSel = 32'h0000_0021;
  reg  [127:0] trigPos = {96'h0, 16'h8000, 16'h0100};
  reg  [15:0]  trigDir = 16'h0007;
  reg  [15:0]  trigAct = 16'h0004;
  reg          autoClr = 1'b0;
  reg  [7:0]   flagClr = 8'h00;
  reg          keyWrite = 1'b0;
  reg  [15:0]  keyData = 16'h0000;
  reg          saveBit = 1'b0;
  reg          factBit = 1'b0;
  reg          fwUpd = 1'b0;
  reg  [7:0]   nvmLat = 8'h01;
  wire         measReq, nvmDone, nvmStrobe, nvmFact, devReset;
  wire [7:0]   flags;
  wire [15:0]  mismatch;
  wire [3:0]   ioOut;
  integer      bad_count = 0;
  integer      n_checks = 0;
  integer      lows, strobes, resets;
  reg          sawFact;

  initial forever #5 clk = ~clk;

  ptl_trigger_io #(.BLINK_HALF_CYC(8)) u_ptl_trigger_io (
    .clk(clk), .srst(srst), .ce(ce), .measDone(measDone), .measValid(measValid),
    .measAmplitude(measAmp), .sensorType(3'h1), .sensorSubtype(8'h00),
    .reportedPosition16(pos16), .reportedPosition32(32'h0000_0000),
    .coarsePosition(coarse), .finePosition(fine), .continuousRun(1'b1),
    .startBit(startBit), .triggerRunEnable(runEnable), .incrementalEnable(incEnable),
    .measureRequest(measReq), .ledIoSelect(ledSel), .ledAmplitudeThreshold(12'h100),
    .ioActiveHigh(ioHigh), .triggerEnable(trigEn), .triggerIoSelect(trigSel),
    .triggerPosition(trigPos), .triggerDirection(trigDir), .triggerAction(trigAct),
    .triggerAutoClear(autoClr), .triggerHysteresisSetting(hyst),
    .triggerFlagClear(flagClr), .triggerFlag(flags), .positionMismatch(mismatch),
    .ioOut(ioOut), .keyWrite(keyWrite), .keyData(keyData), .saveBit(saveBit),
    .factoryBit(factBit), .firmwareUpdated(fwUpd), .nvmWriteDone(nvmDone),
    .nvmWriteStrobe(nvmStrobe), .nvmRestoreFactory(nvmFact), .deviceResetRequest(devReset));

  ptl_nvm_model u_ptl_nvm_model (.clk(clk), .srst(srst), .latency(nvmLat),
    .nvmWriteStrobe(nvmStrobe), .nvmWriteDone(nvmDone));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // One result; steps stay below half scale
  task meas(input v, input [11:0] amp, input [15:0] p);
    begin
      @(posedge clk);
      measDone <= 1'b1;
      measValid <= v;
      measAmp <= amp;
      pos16 <= p;
      @(posedge clk);
      measDone <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  task clear_flags;
    begin
      @(posedge clk);
      flagClr <= 8'hFF;
      @(posedge clk);
      flagClr <= 8'h00;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  task count_low(input integer n);
    begin
      lows = 0;
      repeat (n) begin
        @(posedge clk);
        #1;
        if (ioOut[3] === 1'b0) lows = lows + 1;
      end
    end
  endtask

  // Key write, then save (0), factory (1) or firmware update (2)
  task nvm_op(input [15:0] key, input [1:0] op, input [15:0] expN, input [15:0] expF);
    begin
      @(posedge clk);
      keyWrite <= 1'b1;
      keyData <= key;
      @(posedge clk);
      keyWrite <= 1'b0;
      saveBit <= (op == 2'h0);
      factBit <= (op == 2'h1);
      fwUpd <= (op == 2'h2);
      @(posedge clk);
      saveBit <= 1'b0;
      factBit <= 1'b0;
      fwUpd <= 1'b0;
      strobes = 0;
      resets = 0;
      sawFact = 1'b0;
      // The strobe stands only in the cycle after this edge
      repeat (40) begin
        #1;
        if (nvmStrobe === 1'b1) begin
          strobes = strobes + 1;
          sawFact = nvmFact;
        end
        if (devReset === 1'b1) resets = resets + 1;
        @(posedge clk);
      end
      chk(strobes[15:0], expN);
      chk(resets[15:0], expN);
      chk(16'(sawFact), expF);
    end
  endtask

  task complete_run;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    bad_count = bad_count + 1;
    complete_run;
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(measReq), 16'h0001);
    @(posedge clk);
    startBit <= 1'b0;
    fine <= 16'h0003;
    #1;
    chk(16'(measReq), 16'h0000);
    meas(1'b1, 12'h000, 16'h0000);
    chk(mismatch, 16'hFFFD);
    @(posedge clk);
    ce <= 1'b0;
    coarse <= 16'h0010;
    meas(1'b1, 12'h000, 16'h0000);
    chk(mismatch, 16'hFFFD);
    @(posedge clk);
    ce <= 1'b1;
    meas(1'b1, 12'h000, 16'h0000);
    chk(mismatch, 16'h000D);
    @(posedge clk);
    incEnable <= 1'b1;
    meas(1'b1, 12'h000, 16'h0200);
    chk(mismatch, 16'h0200);
    chk(16'(flags), 16'h0001);
    chk(16'(ioOut[0]), 16'h0001);
    clear_flags;
    chk(16'(ioOut[0]), 16'h0000);
    meas(1'b0, 12'h000, 16'h0200);
    meas(1'b1, 12'h000, 16'h0000);
    chk(16'(flags), 16'h0000);
    meas(1'b1, 12'h000, 16'h0200);
    chk(16'(flags), 16'h0001);
    clear_flags;
    @(posedge clk);
    runEnable <= 1'b0;
    meas(1'b1, 12'h000, 16'h0000);
    chk(16'(flags), 16'h0000);
    @(posedge clk);
    runEnable <= 1'b1;
    trigEn <= 8'h02;
    meas(1'b1, 12'h000, 16'h7FFF);
    meas(1'b1, 12'h000, 16'h8000);
    chk(16'(flags), 16'h0002);
    chk(16'(ioOut[1]), 16'h0001);
    meas(1'b1, 12'h000, 16'h7FFF);
    chk(16'(ioOut[1]), 16'h0001);
    @(posedge clk);
    trigEn <= 8'h01;
    autoClr <= 1'b1;
    meas(1'b1, 12'h000, 16'h0200);
    clear_flags;
    meas(1'b1, 12'h000, 16'h0000);
    chk(16'(ioOut[0]), 16'h0001);
    repeat (110) @(posedge clk);
    #1;
    chk(16'(ioOut[0]), 16'h0000);
    @(posedge clk);
    trigEn <= 8'h03;
    trigSel <= 32'h0000_0011;
    trigDir <= 16'h000F;
    trigAct <= 16'h000B;
    trigPos <= {96'h0, 16'h0300, 16'h0100};
    meas(1'b1, 12'h000, 16'h0200);
    chk(16'(ioOut[0]), 16'h0001);
    meas(1'b1, 12'h000, 16'h0400);
    chk(16'(ioOut[0]), 16'h0000);
    meas(1'b1, 12'h000, 16'h0200);
    chk(16'(ioOut[0]), 16'h0001);
    @(posedge clk);
    hyst <= 15'h0080;
    meas(1'b1, 12'h000, 16'h0380);
    chk(16'(ioOut[0]), 16'h0000);
    meas(1'b1, 12'h000, 16'h02C0);
    chk(16'(ioOut[0]), 16'h0000);
    @(posedge clk);
    trigEn <= 8'h00;
    ioHigh <= 4'h7;
    @(posedge clk);
    ledSel <= 4'h4;
    @(posedge clk);
    ioHigh <= 4'hF;
    meas(1'b1, 12'h200, 16'h0200);
    count_low(20);
    chk(lows[15:0], 16'h0014);
    meas(1'b1, 12'h050, 16'h0200);
    count_low(32);
    chk(lows[15:0], 16'h0010);
    nvm_op(16'h0C1C, 2'h0, 16'h0001, 16'h0000);
    nvm_op(16'h1234, 2'h0, 16'h0000, 16'h0000);
    @(posedge clk);
    nvmLat <= 8'h14;
    nvm_op(16'h0C1C, 2'h1, 16'h0001, 16'h0001);
    nvm_op(16'h0000, 2'h2, 16'h0001, 16'h0001);
    complete_run;
  end
endmodule // tb
